// ### src/ocp_channel.sv
// output compare / pwm channel with register port and fault handling
//
// Functional notes
// - pwm modes keep compare values in hidden shadow registers
// - timer time base uses that timer's prescaler tick, not its count
// - period value n yields n plus one time base counts
// - in pwm modes shadows load from compare values only when counter equals period; other modes load them every cycle
// - all compare values and period zero keep output low
// - secondary above period keeps output high
// - idle_stop set halts channel during cpu idle
// - time base select: 111 peripheral, 100 timer one, 011..000 timers five..two
// - enable bits 9,8,7 gate comparator, pin b, pin a faults
// - fault status bits 6,5,4 set by hardware, writable by software
// - fault enables and status act only in pwm modes
// - comparator source chosen by channel group of three
// - trigger_clear_select lets counter equal secondary clear trigger_running
// - mode 111 center aligned pwm, 110 edge aligned pwm
// - mode 101 starts low, goes high on primary and low on secondary match continuously
// - mode 100 starts low, one pulse from primary to secondary match
// - mode 011 toggles output on every primary match
// - mode 010 starts high goes low, 001 starts low goes high
// - mode 000 disables the channel
// - control one bits 15 and 14 read zero
// - free running counter wraps from all ones to zero
// - during fault output driven to fault_output_level
// - fault persists until source gone plus new period (only with fault_hold_mode clear) or software clear
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none

module ocp_channel #(
    parameter int CHANNEL_INDEX = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [15:0] reg_rdata,
    input wire logic [3:0] timer_prescale_tick,
    input wire logic timer1_prescale_tick,
    input wire logic cpu_idle,
    input wire logic fault_pin_a,
    input wire logic fault_pin_b,
    input wire logic [2:0] comparator_out,
    output logic compare_output,
    output logic compare_output_oe
);

    localparam int CMP_IDX = (CHANNEL_INDEX - 1) / 3;

    // ----------------------------------------------------------------
    // fault pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;

    // two stages before any logic sees the pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta_q <= 2'h0;
            pin_sync_q <= 2'h0;
        end else begin
            pin_meta_q <= {fault_pin_b, fault_pin_a};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // registers and control state
    // ----------------------------------------------------------------
    ocp_pkg::ocp_con1_s con1_q, con1_d;
    ocp_pkg::ocp_con2_s con2_q, con2_d;
    logic [15:0] primary_q, primary_d;
    logic [15:0] secondary_q, secondary_d;
    logic [15:0] period_q, period_d;
    logic [15:0] count_q, count_d;
    logic [15:0] sh_pri_q, sh_pri_d;
    logic [15:0] sh_sec_q, sh_sec_d;
    logic wave_q, wave_d;
    logic done_q, done_d;
    logic compare_output_d;
    logic compare_output_oe_d;
    logic [15:0] reg_rdata_d;

    logic wr_con1, wr_con2;
    logic is_pwm, tick, run, wrap;
    logic pri_hit, sec_hit;
    logic [15:0] eff_sec;
    logic [2:0] fault_src;
    logic fault_act;

    assign wr_con1 = reg_we && (reg_addr == ocp_pkg::ADDR_CONTROL_ONE);
    assign wr_con2 = reg_we && (reg_addr == ocp_pkg::ADDR_CONTROL_TWO);
    assign is_pwm = (con1_q.compare_mode == ocp_pkg::MODE_PWM_EDGE) ||
                    (con1_q.compare_mode == ocp_pkg::MODE_PWM_CENTER);

    // time base tick selection
    always_comb begin
        if (con1_q.timebase_select == ocp_pkg::TB_PERIPHERAL) begin
            tick = 1'b1;
        end else if (con1_q.timebase_select == ocp_pkg::TB_TIMER_ONE) begin
            tick = timer1_prescale_tick;
        end else if (con1_q.timebase_select <= ocp_pkg::TB_TIMER_FIVE) begin
            tick = timer_prescale_tick[con1_q.timebase_select[1:0]];
        end else begin
            tick = 1'b0;
        end
    end

    // counter run and period match
    // idle halt gate
    assign run = tick && (con1_q.compare_mode != ocp_pkg::MODE_OFF) &&
                 !(con1_q.idle_stop && cpu_idle) &&
                 (!con2_q.trigger_not_sync || con2_q.trigger_running);
    assign wrap = run && is_pwm && (count_q == period_q);
    assign pri_hit = run && (count_q == primary_q);
    assign sec_hit = run && (count_q == secondary_q);
    assign eff_sec = wrap ? secondary_q : sh_sec_q;

    // enabled fault sources, pwm modes only
    always_comb begin
        fault_src[2] = comparator_out[CMP_IDX] && con1_q.fault_input_enable[2];
        fault_src[1] = pin_sync_q[1] && con1_q.fault_input_enable[1];
        fault_src[0] = pin_sync_q[0] && con1_q.fault_input_enable[0];
        if (!is_pwm) begin
            fault_src = 3'h0;
        end
    end
    assign fault_act = is_pwm && (con1_q.fault_status != 3'h0);

    // ----------------------------------------------------------------
    // register file next state
    // ----------------------------------------------------------------
    always_comb begin
        con1_d = con1_q;
        con2_d = con2_q;
        primary_d = primary_q;
        secondary_d = secondary_q;
        period_d = period_q;
        if (wr_con1) begin
            con1_d = reg_wdata;
            con1_d.unused = 2'h0;
        end
        if (reg_we && reg_addr == ocp_pkg::ADDR_PRIMARY) begin
            primary_d = reg_wdata;
        end
        if (reg_we && reg_addr == ocp_pkg::ADDR_SECONDARY) begin
            secondary_d = reg_wdata;
        end
        if (reg_we && reg_addr == ocp_pkg::ADDR_PERIOD) begin
            period_d = reg_wdata;
        end
        // clear on new period if source gone
        if (!con2_q.fault_hold_mode && wrap) begin
            con1_d.fault_status = con1_d.fault_status & fault_src;
        end
        con1_d.fault_status = con1_d.fault_status | fault_src;
        if (con1_q.trigger_clear_select && sec_hit) begin
            con2_d.trigger_running = 1'b0;
        end
        if (wr_con2) begin
            con2_d = reg_wdata;
            con2_d.unused = 1'b0;
        end
    end

    // register file storage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            con1_q <= ocp_pkg::RESET_CONTROL_ONE;
            con2_q <= ocp_pkg::RESET_CONTROL_TWO;
            primary_q <= ocp_pkg::RESET_WORD;
            secondary_q <= ocp_pkg::RESET_WORD;
            period_q <= ocp_pkg::RESET_WORD;
        end else begin
            con1_q <= con1_d;
            con2_q <= con2_d;
            primary_q <= primary_d;
            secondary_q <= secondary_d;
            period_q <= period_d;
        end
    end

    // ----------------------------------------------------------------
    // counter, shadows and waveform next state
    // ----------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        sh_pri_d = sh_pri_q;
        sh_sec_d = sh_sec_q;
        wave_d = wave_q;
        done_d = done_q;
        if (con1_q.compare_mode == ocp_pkg::MODE_OFF) begin
            count_d = 16'h0000;
        end else if (wrap) begin
            count_d = 16'h0000;
        end else if (run) begin
            count_d = count_q + 16'h0001;
        end
        if (!is_pwm || wrap) begin
            sh_pri_d = primary_q;
            sh_sec_d = secondary_q;
        end
        unique case (con1_q.compare_mode)
            ocp_pkg::MODE_OFF: begin
                wave_d = 1'b0;
            end
            ocp_pkg::MODE_SET_HIGH: begin
                if (pri_hit) begin
                    wave_d = 1'b1;
                end
            end
            ocp_pkg::MODE_SET_LOW: begin
                if (pri_hit) begin
                    wave_d = 1'b0;
                end
            end
            ocp_pkg::MODE_TOGGLE: begin
                if (pri_hit) begin
                    wave_d = !wave_q;
                end
            end
            ocp_pkg::MODE_ONE_PULSE: begin
                if (!done_q && pri_hit) begin
                    wave_d = 1'b1;
                end
                if (!done_q && sec_hit && wave_q) begin
                    wave_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            ocp_pkg::MODE_PULSES: begin
                if (pri_hit) begin
                    wave_d = 1'b1;
                end
                if (sec_hit && wave_q) begin
                    wave_d = 1'b0;
                end
            end
            ocp_pkg::MODE_PWM_EDGE: begin
                // active at start, inactive at duty
                if (wrap) begin
                    wave_d = (eff_sec != 16'h0000);
                end else if (run && count_q == sh_sec_q) begin
                    wave_d = 1'b0;
                end
                if (run && eff_sec > period_q) begin
                    wave_d = 1'b1;
                end
            end
            ocp_pkg::MODE_PWM_CENTER: begin
                if (wrap) begin
                    wave_d = 1'b0;
                end else if (run && count_q == sh_pri_q) begin
                    wave_d = 1'b1;
                end else if (run && count_q == sh_sec_q) begin
                    wave_d = 1'b0;
                end
                if (run && eff_sec > period_q) begin
                    wave_d = 1'b1;
                end
            end
        endcase
        // control write re-arms and sets initial level
        if (wr_con1) begin
            wave_d = (reg_wdata[2:0] == ocp_pkg::MODE_SET_LOW);
            done_d = 1'b0;
        end
    end

    // counter and waveform storage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_q <= ocp_pkg::RESET_WORD;
            sh_pri_q <= ocp_pkg::RESET_WORD;
            sh_sec_q <= ocp_pkg::RESET_WORD;
            wave_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            sh_pri_q <= sh_pri_d;
            sh_sec_q <= sh_sec_d;
            wave_q <= wave_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------------------------------
    // pin drive and read data
    // ----------------------------------------------------------------
    always_comb begin
        if (fault_act) begin
            compare_output_d = con2_q.fault_output_level;
        end else begin
            compare_output_d = wave_q ^ con2_q.output_invert;
        end
        compare_output_oe_d = !con2_q.output_tristate ||
                              (fault_act && con2_q.fault_force_output);
        reg_rdata_d = 16'h0000;
        if (reg_re) begin
            unique case (reg_addr)
                ocp_pkg::ADDR_CONTROL_ONE: reg_rdata_d = {2'h0, con1_q[13:0]};
                ocp_pkg::ADDR_CONTROL_TWO: reg_rdata_d = con2_q;
                ocp_pkg::ADDR_PRIMARY: reg_rdata_d = primary_q;
                ocp_pkg::ADDR_SECONDARY: reg_rdata_d = secondary_q;
                ocp_pkg::ADDR_PERIOD: reg_rdata_d = period_q;
                ocp_pkg::ADDR_COUNTER: reg_rdata_d = count_q;
                default: reg_rdata_d = 16'h0000;
            endcase
        end
    end

    // output flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            compare_output <= 1'b0;
            compare_output_oe <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            compare_output <= compare_output_d;
            compare_output_oe <= compare_output_oe_d;
            reg_rdata <= reg_rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence period_end_s;
        wrap;
    endsequence

    sequence restart_s;
        count_q == 16'h0000;
    endsequence

    period_wrap_a: assert property (period_end_s |=> restart_s)
        else $error("counter did not restart after period match");

    shadow_load_a: assert property (period_end_s |=> sh_sec_q == $past(secondary_q))
        else $error("shadow not loaded at period end");

    shadow_hold_a: assert property (is_pwm && !wrap |=> $stable(sh_sec_q))
        else $error("shadow changed mid period");

    zero_duty_a: assert property (con1_q.compare_mode == ocp_pkg::MODE_PWM_EDGE &&
        run && !wr_con1 && period_q == 16'h0000 && secondary_q == 16'h0000 &&
        count_q == 16'h0000 |=> !wave_q)
        else $error("zero duty did not hold output low");

    full_duty_a: assert property (is_pwm && run && eff_sec > period_q && !wr_con1
        |=> wave_q ##1 ($past(fault_act) || compare_output != $past(con2_q.output_invert)))
        else $error("full duty not held high");

    idle_halt_a: assert property (con1_q.idle_stop && cpu_idle &&
        con1_q.compare_mode != ocp_pkg::MODE_OFF |=> $stable(count_q))
        else $error("counter moved while halted in idle");

    fault_drive_a: assert property (fault_act |=> compare_output == $past(con2_q.fault_output_level))
        else $error("fault level not driven");

    fault_gate_a: assert property (!is_pwm && !wr_con1 |=> $stable(con1_q.fault_status))
        else $error("fault status moved outside pwm");

    ctl_read_a: assert property (reg_re && reg_addr == ocp_pkg::ADDR_CONTROL_ONE
        |=> reg_rdata[15:14] == 2'h0)
        else $error("unimplemented control bits read nonzero");

    trig_clear_a: assert property (con1_q.trigger_clear_select && sec_hit && !wr_con2
        |=> !con2_q.trigger_running)
        else $error("trigger_running not cleared on secondary match");

    mode_off_a: assert property (con1_q.compare_mode == ocp_pkg::MODE_OFF && !wr_con1
        |=> count_q == 16'h0000 && !wave_q)
        else $error("disabled channel still active");

    one_pulse_a: assert property (con1_q.compare_mode == ocp_pkg::MODE_ONE_PULSE &&
        done_q && !wr_con1 |=> !wave_q && done_q)
        else $error("single shot pulsed again");

endmodule

`default_nettype wire

// ### src/ocp_pkg.sv
// package: register map, field layouts, mode codes for the compare/pwm channel
package ocp_pkg;

    // ----------------------------------------------------------------
    // register word indexes
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
    localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;
    localparam logic [2:0] ADDR_PRIMARY = 3'h2;
    localparam logic [2:0] ADDR_SECONDARY = 3'h3;
    localparam logic [2:0] ADDR_PERIOD = 3'h4;
    localparam logic [2:0] ADDR_COUNTER = 3'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RESET_CONTROL_ONE = 16'h0000;
    localparam logic [15:0] RESET_CONTROL_TWO = 16'h000C;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ----------------------------------------------------------------
    // compare_mode encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SET_HIGH = 3'h1;
    localparam logic [2:0] MODE_SET_LOW = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_ONE_PULSE = 3'h4;
    localparam logic [2:0] MODE_PULSES = 3'h5;
    localparam logic [2:0] MODE_PWM_EDGE = 3'h6;
    localparam logic [2:0] MODE_PWM_CENTER = 3'h7;

    // ----------------------------------------------------------------
    // timebase_select encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] TB_PERIPHERAL = 3'h7;
    localparam logic [2:0] TB_TIMER_ONE = 3'h4;
    localparam logic [2:0] TB_TIMER_FIVE = 3'h3;

    // control register one layout, msb first
    typedef struct packed {
        logic [1:0] unused;
        logic idle_stop;
        logic [2:0] timebase_select;
        logic [2:0] fault_input_enable;
        logic [2:0] fault_status;
        logic trigger_clear_select;
        logic [2:0] compare_mode;
    } ocp_con1_s;

    // control register two layout, msb first
    typedef struct packed {
        logic fault_hold_mode;
        logic fault_output_level;
        logic fault_force_output;
        logic output_invert;
        logic unused;
        logic [1:0] duty_fine;
        logic cascade;
        logic trigger_not_sync;
        logic trigger_running;
        logic output_tristate;
        logic [4:0] sync_source_select;
    } ocp_con2_s;

endpackage

// ### bench/ocp_pin_model.sv
// pin side model: fault sources and the level seen on the compare pin
`timescale 1ns/1ns
`default_nettype none

module ocp_pin_model (
    input wire logic core_clk,
    input wire logic fa_req,
    input wire logic fb_req,
    input wire logic [2:0] cmp_req,
    input wire logic compare_output,
    input wire logic compare_output_oe,
    output logic fault_pin_a,
    output logic fault_pin_b,
    output logic [2:0] comparator_out,
    output logic pin_level
);
    logic last_q;

    // ------------------------------------------------------------
    // fault sources
    // ------------------------------------------------------------
    // sources start quiet
    initial begin
        fault_pin_a = 1'b0;
        fault_pin_b = 1'b0;
        comparator_out = 3'h0;
        last_q = 1'b0;
    end

    // sources follow a request one cycle late, like a slow board net
    always @(posedge core_clk) begin
        fault_pin_a <= fa_req;
        fault_pin_b <= fb_req;
        comparator_out <= cmp_req;
        if (compare_output_oe) begin
            last_q <= compare_output;
        end
    end

    // undriven pin shows the inverse of its last level, never a stale copy
    assign pin_level = compare_output_oe ? compare_output : ~last_q;
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the compare/pwm channel
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [4:0] ticks = 5'h00;
    logic cpu_idle = 1'b0;
    logic fa_req = 1'b0;
    logic fb_req = 1'b0;
    logic [2:0] cmp_req = 3'h0;
    logic [15:0] reg_rdata;
    logic [15:0] rv;
    logic [2:0] comparator_out;
    logic fault_pin_a, fault_pin_b, compare_output, compare_output_oe, pin_level;
    logic [2:0] lvt [1:5] = '{3'h3, 3'h4, 3'h3, 3'h2, 3'h2};
    int fail_count = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    ocp_channel #(.CHANNEL_INDEX(4)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .timer_prescale_tick(ticks[3:0]), .timer1_prescale_tick(ticks[4]), .cpu_idle(cpu_idle),
        .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b), .comparator_out(comparator_out),
        .compare_output(compare_output), .compare_output_oe(compare_output_oe));

    ocp_pin_model pins (.core_clk(core_clk), .fa_req(fa_req), .fb_req(fb_req),
        .cmp_req(cmp_req), .compare_output(compare_output),
        .compare_output_oe(compare_output_oe), .fault_pin_a(fault_pin_a),
        .fault_pin_b(fault_pin_b), .comparator_out(comparator_out), .pin_level(pin_level));

    // ------------------------------------------------------------
    // bus and pin helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic tk(input logic [4:0] t);
        @(posedge core_clk);
        ticks <= t;
        @(posedge core_clk);
        ticks <= 5'h00;
    endtask

    task automatic lvl(input string what, input logic exp);
        @(negedge core_clk);
        chk(what, {15'h0000, pin_level}, {15'h0000, exp});
    endtask

    // high cycles over 40 clocks, a whole number of periods
    task automatic duty(input logic [15:0] exp);
        logic [15:0] c;
        c = 16'h0000;
        repeat (40) begin
            @(negedge core_clk);
            c = c + {15'h0000, pin_level};
        end
        chk("high cycles", c, exp);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic regs();
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("control one reset", rv, ocp_pkg::RESET_CONTROL_ONE);
        rd(ocp_pkg::ADDR_CONTROL_TWO);
        chk("control two reset", rv, ocp_pkg::RESET_CONTROL_TWO);
        rd(3'h6);
        chk("unmapped", rv, 16'h0000);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'hC000);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("unused bits", rv, 16'h0000);
        wr(ocp_pkg::ADDR_COUNTER, 16'h1234);
        rd(ocp_pkg::ADDR_COUNTER);
        chk("counter read only", rv, 16'h0000);
        chk("drive enable", {15'h0000, compare_output_oe}, 16'h0001);
    endtask

    task automatic pwm(input logic [15:0] per, pri, sec, input logic [2:0] m,
        input logic [15:0] exp);
        wr(ocp_pkg::ADDR_PERIOD, per);
        wr(ocp_pkg::ADDR_PRIMARY, pri);
        wr(ocp_pkg::ADDR_SECONDARY, sec);
        wr(ocp_pkg::ADDR_CONTROL_ONE, {13'h0380, m});
        cyc(16);
        duty(exp);
    endtask

    task automatic faults();
        pwm(16'h0007, 16'h0000, 16'h0003, 3'h6, 16'h0014);
        wr(ocp_pkg::ADDR_CONTROL_TWO, 16'hC01F);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'h1C86);
        fa_req <= 1'b1;
        cyc(8);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("status a", rv, 16'h1C96);
        duty(16'h0028);
        fa_req <= 1'b0;
        cyc(16);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("status a held", rv, 16'h1C96);
        duty(16'h0028);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'h1C86);
        cyc(16);
        duty(16'h0014);
        fb_req <= 1'b1;
        cyc(8);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("status b masked", rv, 16'h1C86);
        fb_req <= 1'b0;
        wr(ocp_pkg::ADDR_CONTROL_TWO, 16'h401F);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'h1E06);
        cmp_req <= 3'h5;
        cyc(8);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("foreign comparators", rv, 16'h1E06);
        cmp_req <= 3'h2;
        cyc(8);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("group comparator", rv, 16'h1E46);
        cmp_req <= 3'h0;
        cyc(24);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("status released", rv, 16'h1E06);
    endtask

    task automatic trig(input logic [15:0] c1, input logic [15:0] exp);
        wr(ocp_pkg::ADDR_CONTROL_ONE, c1);
        wr(ocp_pkg::ADDR_CONTROL_TWO, 16'h00DF);
        cyc(20);
        rd(ocp_pkg::ADDR_CONTROL_TWO);
        chk("trigger running", rv, exp);
        wr(ocp_pkg::ADDR_CONTROL_TWO, 16'h001F);
    endtask

    // each tick line pulsed once; only the selected one may advance the counter
    task automatic tbase(input logic [15:0] c1, input logic idle, input logic [15:0] step);
        logic [15:0] c0;
        wr(ocp_pkg::ADDR_CONTROL_ONE, c1);
        cpu_idle <= idle;
        rd(ocp_pkg::ADDR_COUNTER);
        c0 = rv;
        for (int k = 0; k < 5; k++) tk(5'h01 << k);
        rd(ocp_pkg::ADDR_COUNTER);
        chk("counter step", rv - c0, step);
        cpu_idle <= 1'b0;
    endtask

    // lv holds initial level, level after primary, level after secondary
    task automatic cmp_mode(input logic [2:0] m, input logic [2:0] lv);
        wr(ocp_pkg::ADDR_PRIMARY, 16'h0100);
        wr(ocp_pkg::ADDR_SECONDARY, 16'h0100);
        wr(ocp_pkg::ADDR_CONTROL_ONE, {13'h0000, m});
        rd(ocp_pkg::ADDR_COUNTER);
        // a match fires on the tick taken while the counter sits on the value
        wr(ocp_pkg::ADDR_PRIMARY, rv + 16'h0001);
        wr(ocp_pkg::ADDR_SECONDARY, rv + 16'h0003);
        lvl("initial level", lv[2]);
        tk(5'h01);
        tk(5'h01);
        cyc(4);
        lvl("primary match", lv[1]);
        tk(5'h01);
        tk(5'h01);
        cyc(4);
        lvl("secondary match", lv[0]);
    endtask

    // ------------------------------------------------------------
    // main sequence and closing
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        regs();
        wr(ocp_pkg::ADDR_CONTROL_TWO, 16'h001F);
        pwm(16'h0000, 16'h0000, 16'h0000, 3'h6, 16'h0000);
        pwm(16'h0003, 16'h0000, 16'h0002, 3'h6, 16'h001E);
        pwm(16'h0003, 16'h0000, 16'h0005, 3'h6, 16'h0028);
        pwm(16'h0007, 16'h0000, 16'h0003, 3'h6, 16'h0014);
        pwm(16'h0007, 16'h0002, 16'h0005, 3'h7, 16'h000F);
        faults();
        trig(16'h1C0E, 16'h009F);
        trig(16'h1C06, 16'h00DF);
        wr(ocp_pkg::ADDR_PRIMARY, 16'hF000);
        for (int s = 0; s < 7; s++) tbase({3'h0, s[2:0], 7'h00, 3'h1}, 1'b0, s < 5);
        tbase(16'h2001, 1'b1, 16'h0000);
        tbase(16'h0001, 1'b1, 16'h0001);
        for (int m = 5; m > 0; m--) cmp_mode(m[2:0], lvt[m]);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'h0000);
        cyc(3);
        lvl("disabled level", 1'b0);
        wr(ocp_pkg::ADDR_CONTROL_ONE, 16'h0081);
        fa_req <= 1'b1;
        cyc(8);
        rd(ocp_pkg::ADDR_CONTROL_ONE);
        chk("fault outside pwm", rv, 16'h0081);
        fa_req <= 1'b0;
        end_of_test();
    end

    // watchdog well beyond the thousand or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
